// ==== verif/ddr2_address_decode_ecc_test.sv ====
`timescale 1ns/1ps
module ddr2_address_decode_ecc_test;
    logic aclk = 1'h0, aresetn = 1'h0, link_clk = 1'h0, pk;
    logic [7:0] awaddr = '0, araddr = '0, wr_check, odt, rd_check;
    logic awvalid = '0, wvalid = '0, arvalid = '0, bready = '1, rready = '1;
    logic req_valid = '0, req_write = '0, awready, wready, bvalid, arready;
    logic rvalid, dec_valid, rd_valid, rd_out_valid, rd_ce, rd_ue, irq;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic [31:0] wdata = '0, rdata;
    logic [32:0] req_addr = '0, a, rd_addr;
    logic [63:0] req_wdata = '0, flip = '0, wd, rd_data, rd_out_data;
    logic [11:0] ck_p, ck_n;
    ddr2_map_pkg::dram_addr_s dec;
    logic [143:0] qa[$], qd[$], qr[$];
    int failures = 0, cmp_count = 0, n;
    ddr2_address_decode_ecc u_ddr2_address_decode_ecc (.*);
    dimm_model u_dimm_model (.*);
    initial forever #25 aclk = ~aclk;
    initial begin
        #73;
        forever #200 link_clk = ~link_clk;
    end
    // Each note holds a care mask above the expected value.
    task chk(input logic [143:0] e, input logic [71:0] g);
        cmp_count++;
        if ((g & e[143:72]) !== e[71:0]) begin
            failures++;
            $display("Error t=%0t exp=%h got=%h", $time, e[71:0], g);
        end
    endtask
    // An unknown strobe is treated as a result, so it cannot slip by.
    always @(posedge aclk) begin
        if (aresetn) begin
            if (dec_valid !== 1'h0) chk(qd.pop_front(), {33'h0, odt, dec});
            if (rd_out_valid !== 1'h0) begin
                chk(qr.pop_front(), {6'h0, rd_ce, rd_ue, rd_out_data});
            end
            if (rvalid !== 1'h0) begin
                chk(qa.pop_front(), {37'h0, irq, rresp, rdata});
            end
            if (bvalid !== 1'h0) begin
                chk(qa.pop_front(), {38'h0, bresp, 32'h0});
            end
        end
    end
    task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
        qa.push_back({38'h0, 2'h3, 70'h0, r, 32'h0});
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r,
            input logic i);
        qa.push_back({{72{1'b1}}, 37'h0, i, r, d});
        araddr <= ad;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
    endtask
    task rq(input logic w, input logic [32:0] ad, input logic [143:0] e);
        qd.push_back(e);
        req_write <= w;
        req_addr <= ad;
        req_valid <= 1'h1;
        @(posedge aclk);
        req_valid <= 1'h0;
        repeat (4) @(posedge aclk);
    endtask
    function automatic logic [143:0] dx(input logic [32:0] ad, input logic r,
                                        input logic [7:0] o,
                                        input logic c);
        logic [32:0] l;
        l = ad - (r ? 33'h8000000 : 33'h0);
        if (r) return {33'h0, {39{1'b1}}, 33'h0, o, 4'h9, l[29], l[27],
                       l[28], l[26:16], l[13], l[14], l[15], l[12:3]};
        return {33'h0, {39{1'b1}}, 33'h0, o, 1'h1, c, 2'h0, 1'h0, l[14],
                l[15], l[26:16], 1'h0, l[12], l[13], 1'h0, l[11:3]};
    endfunction
    task stop_test;
        $display("Checks %0d errors %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h4f7d1a24));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(ddr2_map_pkg::OFF_CTRL, 32'h0, 2'h0, 1'h0);
        wr(ddr2_map_pkg::OFF_BOUND_A, 32'h24242404, 2'h0);
        wr(ddr2_map_pkg::OFF_BOUND_B, 32'h24242424, 2'h0);
        wr(ddr2_map_pkg::OFF_ARCH_A, 32'h50, 2'h0);
        wr(ddr2_map_pkg::OFF_MASK, 32'h7, 2'h0);
        wr(ddr2_map_pkg::OFF_CTRL, 32'h5, 2'h0);
        wr(8'h40, 32'h0, ddr2_map_pkg::RESP_SLVERR);
        rd(8'h40, 32'h0, ddr2_map_pkg::RESP_SLVERR, 1'h0);
        // Even passes hit the small rank, odd ones the large rank.
        for (int i = 0; i < 6; i++) begin
            wd = {$urandom, $urandom};
            // Even passes flip from bit 0 so the fixed-pattern checks fire.
            n = i[0] ? $urandom % 63 : 0;
            a = i[0] ? 33'h8000000 + 33'($urandom & 32'h3ffffff8)
                     : 33'($urandom & 32'h7fffff8);
            req_wdata <= wd;
            flip <= (i < 2) ? '0 : (i < 4) ? 64'h1 << n : 64'h3 << n;
            rq(1'h1, a, dx(a, i[0], 8'h1 << i[0], 1'h0));
            qr.push_back(i < 4 ? {6'h0, {66{1'b1}}, 6'h0, i > 1, 1'h0, wd}
                               : {6'h0, 2'h3, 70'h0, 2'h1, 64'h0});
            rq(1'h0, a, dx(a, i[0], 8'h0, 1'h0));
        end
        rd(ddr2_map_pkg::OFF_ERR_LO, a[31:0], 2'h0, 1'h1);
        rq(1'h0, 33'h48000000, {33'h0, 9'h1ff, 102'h0});
        rd(ddr2_map_pkg::OFF_STATUS, 32'h7, 2'h0, 1'h1);
        wr(ddr2_map_pkg::OFF_STATUS, 32'h7, 2'h0);
        rd(ddr2_map_pkg::OFF_STATUS, 32'h0, 2'h0, 1'h0);
        wr(ddr2_map_pkg::OFF_CTRL, 32'h4, 2'h0);
        qr.push_back({{72{1'b1}}, 8'h0, wd ^ flip});
        rq(1'h0, a, dx(a, 1'h1, 8'h0, 1'h0));
        rd(ddr2_map_pkg::OFF_STATUS, 32'h0, 2'h0, 1'h0);
        pk = ck_p[0];
        n = 0;
        repeat (80) begin
            @(posedge aclk);
            n += (ck_p[0] !== pk);
            pk = ck_p[0];
        end
        chk({{72{1'b1}}, 72'hf}, {ck_p[11:3], ck_n[11:3],
            ck_p[2:0] ^ ck_n[2:0], n > 18 && n < 22});
        wr(ddr2_map_pkg::OFF_CTRL, 32'h6, 2'h0);
        a = 33'($urandom & 32'h7fffff8);
        // Two adjacent lines of one rank must land on opposite channels.
        repeat (2) begin
            rq(1'h1, a, dx({1'h0, a[32:7], a[5:0]}, 1'h0,
                           a[6] ? 8'h10 : 8'h1, a[6]));
            a[6] = ~a[6];
        end
        stop_test;
    end
endmodule // ddr2_address_decode_ecc_test

// ==== verif/dimm_model.sv ====
`timescale 1ns/1ps
module dimm_model (
    // Host request
    input wire logic aclk,
    input wire logic req_write,
    input wire logic [32:0] req_addr,
    input wire logic [63:0] req_wdata,
    input wire logic [63:0] flip,
    input wire logic dec_valid,
    input wire ddr2_map_pkg::dram_addr_s dec,
    input wire logic [7:0] wr_check,
    // Read return
    output logic rd_valid,
    output logic [63:0] rd_data,
    output logic [7:0] rd_check,
    output logic [32:0] rd_addr
);
    logic [71:0] mem [16];
    logic [97:0] cmd;
    initial {rd_valid, rd_data, rd_check, rd_addr} = '0;
    // Idle lines toggle so a stale word can never pass for a fresh one.
    always @(posedge aclk) begin
        cmd <= {req_write, req_addr, req_wdata};
        rd_valid <= 1'h0;
        {rd_check, rd_data} <= ~{rd_check, rd_data};
        if (dec_valid && dec.hit && cmd[97]) begin
            mem[dec.col[3:0]] <= {wr_check, cmd[63:0]};
        end else if (dec_valid && dec.hit) begin
            rd_valid <= 1'h1;
            {rd_check, rd_data} <= mem[dec.col[3:0]] ^ {8'h0, flip};
            rd_addr <= cmd[96:64];
        end
    end
endmodule // dimm_model

// ==== verilog/ddr2_address_decode_ecc.sv ====
`timescale 1ns/1ps
module ddr2_address_decode_ecc (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Host request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [32:0] req_addr,
    input wire logic [63:0] req_wdata,
    output logic dec_valid,
    output ddr2_map_pkg::dram_addr_s dec,
    output logic [7:0] wr_check,
    output logic [7:0] odt,
    // Read return
    input wire logic rd_valid,
    input wire logic [63:0] rd_data,
    input wire logic [7:0] rd_check,
    input wire logic [32:0] rd_addr,
    output logic rd_out_valid,
    output logic [63:0] rd_out_data,
    output logic rd_ce,
    output logic rd_ue,
    // DIMM clocks
    input wire logic link_clk,
    output logic [11:0] ck_p,
    output logic [11:0] ck_n,
    // Interrupt
    output logic irq
);

    logic [2:0] ctrl, next_ctrl;
    logic [31:0] bound_a, next_bound_a, bound_b, next_bound_b;
    logic [15:0] arch_a, next_arch_a, arch_b, next_arch_b;
    logic [2:0] status, next_status, mask, next_mask;
    logic [32:0] err_addr, next_err_addr;
    logic [7:0] err_syn, next_err_syn;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] waddr, next_waddr;
    logic [31:0] wbuf, next_wbuf;
    logic [3:0] wsbuf, next_wsbuf;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic next_irq;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic do_write;

    logic [7:0] bnd [8];
    logic [7:0] prev, top, base_c;
    logic [7:0] pop;
    logic hit_c, chan_c;
    logic [1:0] rank_c;
    logic [32:0] local_c, shifted_c;
    logic [15:0] arch_sel;
    logic [2:0] tech_c;
    ddr2_map_pkg::dram_addr_s next_dec;
    logic next_dec_valid;
    logic [7:0] next_wr_check, next_odt;
    logic [7:0] syn;
    logic single, double;
    logic [63:0] corr;
    logic next_rd_ce, next_rd_ue, next_rd_out_valid;
    logic [63:0] next_rd_out_data;
    logic [2:0] events;

    logic link_s1, link_s2;
    logic [11:0] next_ck_p, next_ck_n;

    // Address decode, ECC and termination control.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bnd[i] = bound_a[i*8 +: 8];
            bnd[i+4] = bound_b[i*8 +: 8];
        end
        prev = 8'h0;
        top = 8'h0;
        base_c = 8'h0;
        hit_c = 1'b0;
        chan_c = 1'b0;
        rank_c = 2'h0;
        pop = 8'h0;
        // Asymmetric mode walks A then B, so B continues where A ends.
        for (int i = 0; i < 8; i++) begin
            top = bnd[i];
            if (!(ctrl[ddr2_map_pkg::CTRL_ILV] && i >= 4)) begin
                pop[i] = top > prev;
                if (!hit_c && req_addr[32:25] < top) begin
                    hit_c = 1'b1;
                    chan_c = i[2];
                    rank_c = i[1:0];
                    base_c = prev;
                end
                prev = top;
            end else begin
                pop[i] = pop[i-4];
            end
        end
        local_c = req_addr - {base_c, 25'h0};
        shifted_c = local_c;
        if (ctrl[ddr2_map_pkg::CTRL_ILV]) begin
            chan_c = local_c[6];
            shifted_c = {1'b0, local_c[32:7], local_c[5:0]};
        end
        arch_sel = chan_c ? arch_b : arch_a;
        tech_c = arch_sel[{rank_c, 2'b00} +: 3];
        next_dec = ddr2_map_pkg::map_bits(tech_c, shifted_c);
        next_dec.hit = hit_c;
        next_dec.chan = chan_c;
        next_dec.rank = rank_c;
        next_dec_valid = req_valid;
        next_wr_check = 8'h0;
        if (req_valid && ctrl[ddr2_map_pkg::CTRL_ECC_EN]) begin
            next_wr_check = ddr2_map_pkg::ecc_encode(req_wdata);
        end
        // Writes terminate the target; reads use the other DIMM.
        next_odt = 8'h0;
        if (req_valid && hit_c && ctrl[ddr2_map_pkg::CTRL_ODT_EN]) begin
            for (int i = 0; i < 8; i++) begin
                if (i[2] == chan_c) begin
                    if (req_write) begin
                        next_odt[i] = i[1:0] == rank_c;
                    end else begin
                        next_odt[i] = pop[i] && i[1] != rank_c[1];
                    end
                end
            end
        end
        syn = ddr2_map_pkg::ecc_encode(rd_data) ^ rd_check;
        // Three or more bits in error may alias to a single fix.
        single = ^{rd_data, rd_check};
        double = !single && syn[6:0] != 7'h0;
        corr = rd_data;
        for (int i = 0; i < 64; i++) begin
            if (single && ddr2_map_pkg::ham_pos(i) == syn[6:0]) begin
                corr[i] = ~rd_data[i];
            end
        end
        next_rd_out_valid = rd_valid;
        next_rd_out_data = rd_data;
        next_rd_ce = 1'b0;
        next_rd_ue = 1'b0;
        if (rd_valid && ctrl[ddr2_map_pkg::CTRL_ECC_EN]) begin
            next_rd_out_data = corr;
            next_rd_ce = single;
            next_rd_ue = double;
        end
        events = 3'h0;
        events[ddr2_map_pkg::STS_CE] = next_rd_ce;
        events[ddr2_map_pkg::STS_UE] = next_rd_ue;
        events[ddr2_map_pkg::STS_MISS] = req_valid && !hit_c;
        next_err_addr = err_addr;
        next_err_syn = err_syn;
        if (next_rd_ce || next_rd_ue) begin
            next_err_addr = rd_addr;
            next_err_syn = syn;
        end
    end

    // Register file and AXI4-Lite handshakes.
    assign wa = aw_held ? waddr : awaddr;
    assign wd = w_held ? wbuf : wdata;
    assign ws = w_held ? wsbuf : wstrb;
    assign do_write = (aw_held || (awvalid && awready)) &&
                      (w_held || (wvalid && wready)) && !bvalid;

    always_comb begin
        next_ctrl = ctrl;
        next_bound_a = bound_a;
        next_bound_b = bound_b;
        next_arch_a = arch_a;
        next_arch_b = arch_b;
        next_mask = mask;
        next_status = status | events;
        next_aw_held = aw_held || (awvalid && awready);
        next_w_held = w_held || (wvalid && wready);
        next_waddr = awvalid && awready ? awaddr : waddr;
        next_wbuf = wvalid && wready ? wdata : wbuf;
        next_wsbuf = wvalid && wready ? wstrb : wsbuf;
        next_bvalid = bvalid && !bready;
        next_bresp = bresp;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ddr2_map_pkg::RESP_OKAY;
            case (wa)
                ddr2_map_pkg::OFF_CTRL: if (ws[0]) next_ctrl = wd[2:0];
                ddr2_map_pkg::OFF_BOUND_A:
                    next_bound_a = ddr2_map_pkg::wmerge(bound_a, wd, ws);
                ddr2_map_pkg::OFF_BOUND_B:
                    next_bound_b = ddr2_map_pkg::wmerge(bound_b, wd, ws);
                ddr2_map_pkg::OFF_ARCH_A: next_arch_a = 16'(
                    ddr2_map_pkg::wmerge({16'h0, arch_a}, wd, ws));
                ddr2_map_pkg::OFF_ARCH_B: next_arch_b = 16'(
                    ddr2_map_pkg::wmerge({16'h0, arch_b}, wd, ws));
                // A new event in the same cycle survives the clear.
                ddr2_map_pkg::OFF_STATUS: if (ws[0]) begin
                    next_status = (status & ~wd[2:0]) | events;
                end
                ddr2_map_pkg::OFF_MASK: if (ws[0]) next_mask = wd[2:0];
                ddr2_map_pkg::OFF_ERR_LO, ddr2_map_pkg::OFF_ERR_HI: ;
                default: next_bresp = ddr2_map_pkg::RESP_SLVERR;
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_rvalid = rvalid && !rready;
        next_rdata = rdata;
        next_rresp = rresp;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = ddr2_map_pkg::RESP_OKAY;
            case (araddr)
                ddr2_map_pkg::OFF_CTRL: next_rdata = {29'h0, ctrl};
                ddr2_map_pkg::OFF_BOUND_A: next_rdata = bound_a;
                ddr2_map_pkg::OFF_BOUND_B: next_rdata = bound_b;
                ddr2_map_pkg::OFF_ARCH_A: next_rdata = {16'h0, arch_a};
                ddr2_map_pkg::OFF_ARCH_B: next_rdata = {16'h0, arch_b};
                ddr2_map_pkg::OFF_STATUS: next_rdata = {29'h0, status};
                ddr2_map_pkg::OFF_MASK: next_rdata = {29'h0, mask};
                ddr2_map_pkg::OFF_ERR_LO: next_rdata = err_addr[31:0];
                ddr2_map_pkg::OFF_ERR_HI:
                    next_rdata = {16'h0, err_syn, 7'h0, err_addr[32]};
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = ddr2_map_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
        next_irq = |(next_status & next_mask);
    end

    // Every pair of a DIMM toggles only while that DIMM holds a rank.
    always_comb begin
        for (int k = 0; k < ddr2_map_pkg::CK_W; k++) begin
            next_ck_p[k] = link_s2 &&
                |pop[(k / ddr2_map_pkg::CK_PER_CH) * 4 +
                     (k % ddr2_map_pkg::CK_PER_CH) /
                     ddr2_map_pkg::CK_PER_DIMM * 2 +: 2];
            next_ck_n[k] = !link_s2 &&
                |pop[(k / ddr2_map_pkg::CK_PER_CH) * 4 +
                     (k % ddr2_map_pkg::CK_PER_CH) /
                     ddr2_map_pkg::CK_PER_DIMM * 2 +: 2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= ddr2_map_pkg::CTRL_RST;
            bound_a <= ddr2_map_pkg::BOUND_RST;
            bound_b <= ddr2_map_pkg::BOUND_RST;
            arch_a <= ddr2_map_pkg::ARCH_RST;
            arch_b <= ddr2_map_pkg::ARCH_RST;
            status <= ddr2_map_pkg::STS_RST;
            mask <= ddr2_map_pkg::STS_RST;
            err_addr <= 33'h0;
            err_syn <= 8'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= 8'h0;
            wbuf <= 32'h0;
            wsbuf <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
            irq <= 1'b0;
            dec_valid <= 1'b0;
            dec <= '0;
            wr_check <= 8'h0;
            odt <= 8'h0;
            rd_out_valid <= 1'b0;
            rd_out_data <= 64'h0;
            rd_ce <= 1'b0;
            rd_ue <= 1'b0;
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            ck_p <= 12'h0;
            ck_n <= 12'h0;
        end else begin
            ctrl <= next_ctrl;
            bound_a <= next_bound_a;
            bound_b <= next_bound_b;
            arch_a <= next_arch_a;
            arch_b <= next_arch_b;
            status <= next_status;
            mask <= next_mask;
            err_addr <= next_err_addr;
            err_syn <= next_err_syn;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            waddr <= next_waddr;
            wbuf <= next_wbuf;
            wsbuf <= next_wsbuf;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            irq <= next_irq;
            dec_valid <= next_dec_valid;
            dec <= next_dec;
            wr_check <= next_wr_check;
            odt <= next_odt;
            rd_out_valid <= next_rd_out_valid;
            rd_out_data <= next_rd_out_data;
            rd_ce <= next_rd_ce;
            rd_ue <= next_rd_ue;
            link_s1 <= link_clk;
            link_s2 <= link_s1;
            ck_p <= next_ck_p;
            ck_n <= next_ck_n;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ecc_off;
        req_valid && !ctrl[ddr2_map_pkg::CTRL_ECC_EN] |=> wr_check == 8'h0;
    endproperty
    a_ecc_off: assert property (p_ecc_off)
        else $error("check bits driven while ECC disabled");

    property p_ecc_gen;
        req_valid && ctrl[ddr2_map_pkg::CTRL_ECC_EN] |=>
            wr_check == ddr2_map_pkg::ecc_encode($past(req_wdata));
    endproperty
    a_ecc_gen: assert property (p_ecc_gen)
        else $error("check bits do not match written quadword");

    property p_clean;
        rd_valid && ctrl[ddr2_map_pkg::CTRL_ECC_EN] &&
        rd_check == ddr2_map_pkg::ecc_encode(rd_data) |=>
            rd_out_valid && !rd_ce && !rd_ue &&
            rd_out_data == $past(rd_data);
    endproperty
    a_clean: assert property (p_clean)
        else $error("clean quadword flagged or altered");

    property p_single;
        rd_valid && ctrl[ddr2_map_pkg::CTRL_ECC_EN] &&
        rd_check == ddr2_map_pkg::ecc_encode(rd_data ^ 64'h1) |=>
            rd_ce && !rd_ue && rd_out_data == ($past(rd_data) ^ 64'h1);
    endproperty
    a_single: assert property (p_single)
        else $error("single-bit error not corrected");

    property p_double;
        rd_valid && ctrl[ddr2_map_pkg::CTRL_ECC_EN] &&
        rd_check == ddr2_map_pkg::ecc_encode(rd_data ^ 64'h3) |=>
            rd_ue && !rd_ce;
    endproperty
    a_double: assert property (p_double)
        else $error("double-bit error not detected");

    property p_err_log;
        rd_ce || rd_ue |-> status[ddr2_map_pkg::STS_CE] |
            status[ddr2_map_pkg::STS_UE] && err_addr == $past(rd_addr);
    endproperty
    a_err_log: assert property (p_err_log)
        else $error("ECC event not logged with its address");

    property p_ilv_chan;
        req_valid && ctrl[ddr2_map_pkg::CTRL_ILV] |=>
            !dec.hit || dec.chan == $past(req_addr[6]);
    endproperty
    a_ilv_chan: assert property (p_ilv_chan)
        else $error("interleaved channel not taken from address bit 6");

    property p_col_low;
        req_valid && !ctrl[ddr2_map_pkg::CTRL_ILV] |=>
            !dec.hit || dec.col[8:0] == $past(req_addr[11:3]);
    endproperty
    a_col_low: assert property (p_col_low)
        else $error("column bits not taken from host bits 3 to 11");

    property p_odt_wr;
        req_valid && req_write && ctrl[ddr2_map_pkg::CTRL_ODT_EN] |=>
            !dec.hit || odt[{dec.chan, dec.rank}];
    endproperty
    a_odt_wr: assert property (p_odt_wr)
        else $error("termination not enabled on written rank");

    property p_ck_diff;
        (ck_p & ck_n) == 12'h0;
    endproperty
    a_ck_diff: assert property (p_ck_diff)
        else $error("clock pair legs high together");

    property p_irq;
        (status & mask) != 3'h0 |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt low with unmasked status set");

    c_ilv: cover property (dec_valid && dec.hit &&
        ctrl[ddr2_map_pkg::CTRL_ILV]);
    c_ce: cover property (rd_ce);
    c_ue: cover property (rd_ue);
    c_wr: cover property (bvalid && bready);

endmodule // ddr2_address_decode_ecc

// ==== verilog/ddr2_map_pkg.sv ====
package ddr2_map_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BOUND_A = 8'h04;
    localparam logic [7:0] OFF_BOUND_B = 8'h08;
    localparam logic [7:0] OFF_ARCH_A = 8'h0c;
    localparam logic [7:0] OFF_ARCH_B = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_ERR_LO = 8'h1c;
    localparam logic [7:0] OFF_ERR_HI = 8'h20;

    // Control fields.
    localparam int CTRL_ECC_EN = 0;
    localparam int CTRL_ILV = 1;
    localparam int CTRL_ODT_EN = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // Status and mask fields.
    localparam int STS_CE = 0;
    localparam int STS_UE = 1;
    localparam int STS_MISS = 2;
    localparam int STS_W = 3;
    localparam logic [2:0] STS_RST = 3'h0;

    // Rank boundaries in 32 MB units, one byte per rank.
    localparam int BOUND_SHIFT = 25;
    localparam logic [31:0] BOUND_RST = 32'h0;
    localparam logic [15:0] ARCH_RST = 16'h0;
    localparam int ERR_SYN_POS = 8;

    // Rank architecture codes, one 3-bit field per rank nibble.
    localparam logic [2:0] TECH_256X16 = 3'h0;
    localparam logic [2:0] TECH_256X8 = 3'h1;
    localparam logic [2:0] TECH_512X16 = 3'h2;
    localparam logic [2:0] TECH_512X8 = 3'h3;
    localparam logic [2:0] TECH_1GX16 = 3'h4;
    localparam logic [2:0] TECH_1GX8 = 3'h5;

    // Clock pairs: three per DIMM, two DIMMs per channel.
    localparam int CK_PER_DIMM = 3;
    localparam int CK_PER_CH = 6;
    localparam int CK_W = 12;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic hit;
        logic chan;
        logic [1:0] rank;
        logic [13:0] row;
        logic [2:0] bank;
        logic [9:0] col;
    } dram_addr_s;

    // Hamming position of data bit idx, skipping check-bit positions.
    function automatic logic [6:0] ham_pos(input int idx);
        int n;
        logic [6:0] p;
        logic [6:0] res;
        n = 0;
        res = 7'h0;
        for (int q = 3; q < 72; q++) begin
            p = q[6:0];
            if ((p & (p - 7'h1)) != 7'h0) begin
                if (n == idx) res = p;
                n++;
            end
        end
        return res;
    endfunction

    // Seven Hamming bits plus overall parity in bit 7.
    function automatic logic [7:0] ecc_encode(input logic [63:0] d);
        logic [7:0] c;
        logic [6:0] p;
        c = 8'h0;
        for (int i = 0; i < 64; i++) begin
            p = ham_pos(i);
            for (int k = 0; k < 7; k++) begin
                if (p[k]) c[k] = c[k] ^ d[i];
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction

    function automatic dram_addr_s map_bits(input logic [2:0] tech,
                                            input logic [32:0] a);
        dram_addr_s r;
        r = '0;
        case (tech)
            TECH_256X16: begin
                r.col = {1'b0, a[11:3]};
                r.bank = {1'b0, a[12], a[13]};
                r.row = {1'b0, a[14], a[15], a[26:16]};
            end
            TECH_256X8, TECH_512X16, TECH_512X8: begin
                r.col = a[12:3];
                r.bank = {1'b0, a[14], a[13]};
                r.row = {(tech == TECH_512X8) & a[28], a[27], a[15],
                         a[26:16]};
            end
            TECH_1GX16, TECH_1GX8: begin
                r.col = a[12:3];
                r.bank = {a[13], a[14], a[15]};
                r.row = {(tech == TECH_1GX8) & a[29], a[27], a[28],
                         a[26:16]};
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

endpackage
